// ### verilog/bct_regs.svh
// Constants for the bus cycle termination and interrupt acknowledge ends
// Function
// - Alternate acknowledge drives fixed address and modifier pattern
// - Acknowledge is a byte read with transfer start
// - Transfer start negated in the second cycle
// - Peripheral returns vector with enable and acknowledge
// - Acknowledge ends cycle, otherwise wait and resample
// - Peripheral drops enable and acknowledge next cycle, except between beats of a line
// - Unanswered acknowledge gets vector 24 with error
// - Spurious vector latched on the error edge
// - Spurious acknowledge may end with normal acknowledge
// - Far end raises error after a timeout
// - Acknowledge and error switch on one edge
// - Error wins, acknowledge completes, neither waits
// - Error abandons remaining longwords of a line
// - Prefetch error pends until used, branch discards
// - Later line longword error only if requested
// - Misaligned operand error in either longword immediate
// - Write or requested read error is immediate
// - Instruction fill invalidates line, stays invalid on error
// - Buffered write error not tied to instruction
// - Access errors come from three sources only
// - Error while stacking halts with status F
// - Bus reset held at least six cycles
// - Static strap selects alternate acknowledge encoding
`ifndef BCT_REGS_SVH
`define BCT_REGS_SVH

`define BCT_SIZE_LONG 2'h0
`define BCT_SIZE_BYTE 2'h1
`define BCT_SIZE_LINE 2'h3
`define BCT_TT_NORMAL 2'h0
`define BCT_TT_ALT_IACK 2'h0
`define BCT_TT_NAT_IACK 2'h3
`define BCT_TM_NORMAL 3'h0
`define BCT_TM_ALT_IACK 3'h7
`define BCT_ALT_ADDR_HI 28'hFFFFFFF
`define BCT_NAT_ADDR_HI 27'h7FFFFFF
`define BCT_ALT_ADDR_LO 1'h1
`define BCT_NAT_ADDR_LO 2'h0
`define BCT_VEC_MSB 31
`define BCT_VEC_LSB 24
`define BCT_SPURIOUS_VEC 8'h18
`define BCT_PST_RUN 4'h0
`define BCT_PST_HALT 4'hF
`define BCT_LAST_BEAT 2'h3
`define BCT_RST_CYCLES 3'h6
`define BCT_CLK_NS 8
`define BCT_TIMEOUT_NS 2000
`define BCT_TIMEOUT_CYC ((`BCT_TIMEOUT_NS + `BCT_CLK_NS - 1) / `BCT_CLK_NS)

`endif

// ### verilog/bct_pkg.sv
// Types for the bus termination link: request kinds and the state of each end
package bct_pkg;

   typedef enum logic [2:0] {
      BCT_KIND_OPERAND,
      BCT_KIND_PREFETCH,
      BCT_KIND_LINE_INSTR,
      BCT_KIND_LINE_DATA,
      BCT_KIND_WRITE,
      BCT_KIND_BUF_WRITE,
      BCT_KIND_IACK
   } bct_kind_t;

   typedef enum logic [1:0] {
      BCT_ST_IDLE,
      BCT_ST_START,
      BCT_ST_WAIT,
      BCT_ST_HALT
   } bct_core_state_t;

   typedef enum logic {
      BCT_PS_IDLE,
      BCT_PS_BUSY
   } bct_peer_state_t;

endpackage

// ### verilog/bct_bus_if.sv
// Master bus signals between the processor end and the peripheral end
`timescale 1ns/1ps
interface bct_bus_if;
   logic [31:0] master_address;
   logic [2:0] transfer_modifier;
   logic [1:0] transfer_type;
   logic read_write_n;
   logic [1:0] transfer_size;
   logic transfer_start_n;
   logic [31:0] read_data_bus;
   logic input_enable;
   logic transfer_ack_n;
   logic transfer_error_ack_n;
   logic bus_reset_n;

   modport core (
      output master_address,
      output transfer_modifier,
      output transfer_type,
      output read_write_n,
      output transfer_size,
      output transfer_start_n,
      input read_data_bus,
      input input_enable,
      input transfer_ack_n,
      input transfer_error_ack_n,
      input bus_reset_n
   );

   modport peer (
      input master_address,
      input transfer_modifier,
      input transfer_type,
      input read_write_n,
      input transfer_size,
      input transfer_start_n,
      output read_data_bus,
      output input_enable,
      output transfer_ack_n,
      output transfer_error_ack_n,
      output bus_reset_n
   );
endinterface

// ### verilog/bct_timeout.sv
// Bus cycle watchdog: pulses once when a cycle runs too long
`timescale 1ns/1ps
`include "bct_regs.svh"
module bct_timeout (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Control
   input wire logic clear_i,
   input wire logic run_i,
   // Result
   output logic expired_o
);
   localparam logic [8:0] LIMIT = 9'(`BCT_TIMEOUT_CYC);

   logic [8:0] cnt_q, cnt_d;
   logic exp_d;

   always_comb begin
      cnt_d = cnt_q;
      exp_d = 1'b0;
      if (clear_i || !run_i) begin
         cnt_d = 9'h000;
      end else if (cnt_q != LIMIT) begin
         cnt_d = cnt_q + 9'h001;
         exp_d = (cnt_q == LIMIT - 9'h001);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt_q <= 9'h000;
         expired_o <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         expired_o <= exp_d;
      end
   end
endmodule

// ### verilog/bct_peer_end.sv
// Far end: interrupting peripheral, read responder, timeout and reset source
`timescale 1ns/1ps
`include "bct_regs.svh"
module bct_peer_end (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Bus
   bct_bus_if.peer bus,
   // Responder setup
   input wire logic rst_req_i,
   input wire logic iack_present_i,
   input wire logic [7:0] iack_vector_i,
   input wire logic spur_use_ack_i,
   input wire logic dev_present_i,
   input wire logic err_inject_i,
   input wire logic [3:0] wait_cycles_i,
   input wire logic [31:0] rd_data_i,
   // Observations
   output logic cyc_seen_o,
   output logic iack_seen_o,
   output logic timeout_o
);
   bct_pkg::bct_peer_state_t state_q, state_d;
   logic [3:0] wcnt_q, wcnt_d;
   logic [1:0] beat_q, beat_d;
   logic iack_q, iack_d, line_q, line_d, read_q, read_d;
   logic [31:0] data_q, data_d;
   logic ie_q, ie_d, ack_n_q, ack_n_d, err_n_q, err_n_d;
   logic [2:0] rcnt_q, rcnt_d;
   logic rstn_q, rstn_d;
   logic seen_d, iseen_d, to_d;
   logic start_seen, go, expired;
   logic [3:0] cur_wait;

   bct_timeout u_timeout (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clear_i(start_seen),
      .run_i(state_q == bct_pkg::BCT_PS_BUSY),
      .expired_o(expired)
   );

   always_comb begin
      state_d = state_q;
      wcnt_d = wcnt_q;
      beat_d = beat_q;
      iack_d = iack_q;
      line_d = line_q;
      read_d = read_q;
      data_d = 32'h00000000;
      ie_d = 1'b0;
      ack_n_d = 1'b1;
      err_n_d = 1'b1;
      seen_d = 1'b0;
      iseen_d = 1'b0;
      to_d = 1'b0;
      start_seen = (state_q == bct_pkg::BCT_PS_IDLE) && !bus.transfer_start_n;
      go = start_seen || (state_q == bct_pkg::BCT_PS_BUSY);
      cur_wait = start_seen ? wait_cycles_i : wcnt_q;
      if (start_seen) begin
         seen_d = 1'b1;
         beat_d = 2'h0;
         read_d = bus.read_write_n;
         line_d = (bus.transfer_size == `BCT_SIZE_LINE);
         iack_d = bus.read_write_n && (bus.transfer_size == `BCT_SIZE_BYTE) &&
                  (((bus.transfer_type == `BCT_TT_ALT_IACK) && (bus.transfer_modifier == `BCT_TM_ALT_IACK)) ||
                   (bus.transfer_type == `BCT_TT_NAT_IACK));
         iseen_d = iack_d;
      end
      if (go) begin
         state_d = bct_pkg::BCT_PS_BUSY;
         if (expired) begin
            // Nobody answered: end the cycle ourselves
            to_d = 1'b1;
            state_d = bct_pkg::BCT_PS_IDLE;
            ie_d = read_d;
            if (iack_d) begin
               data_d[`BCT_VEC_MSB:`BCT_VEC_LSB] = `BCT_SPURIOUS_VEC;
            end
            if (iack_d && spur_use_ack_i) begin
               ack_n_d = 1'b0;
            end else begin
               err_n_d = 1'b0;
            end
         end else if (cur_wait != 4'h0) begin
            wcnt_d = cur_wait - 4'h1;
         end else if (iack_d ? iack_present_i : dev_present_i) begin
            ie_d = read_d;
            wcnt_d = 4'h0;
            if (iack_d) begin
               data_d[`BCT_VEC_MSB:`BCT_VEC_LSB] = iack_vector_i;
            end else if (read_d) begin
               data_d = rd_data_i;
            end
            if (err_inject_i && !iack_d) begin
               err_n_d = 1'b0;
               state_d = bct_pkg::BCT_PS_IDLE;
            end else begin
               ack_n_d = 1'b0;
               if (line_d && (beat_q != `BCT_LAST_BEAT)) begin
                  beat_d = beat_q + 2'h1;
               end else begin
                  state_d = bct_pkg::BCT_PS_IDLE;
               end
            end
         end
      end
      rcnt_d = rcnt_q;
      rstn_d = rstn_q;
      if (rst_req_i) begin
         rcnt_d = 3'h0;
         rstn_d = 1'b0;
      end else if (rcnt_q != `BCT_RST_CYCLES) begin
         rcnt_d = rcnt_q + 3'h1;
         rstn_d = 1'b0;
      end else begin
         rstn_d = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q <= bct_pkg::BCT_PS_IDLE;
         wcnt_q <= 4'h0;
         beat_q <= 2'h0;
         iack_q <= 1'b0;
         line_q <= 1'b0;
         read_q <= 1'b0;
         data_q <= 32'h00000000;
         ie_q <= 1'b0;
         ack_n_q <= 1'b1;
         err_n_q <= 1'b1;
         rcnt_q <= 3'h0;
         rstn_q <= 1'b0;
         cyc_seen_o <= 1'b0;
         iack_seen_o <= 1'b0;
         timeout_o <= 1'b0;
      end else begin
         state_q <= rstn_q ? state_d : bct_pkg::BCT_PS_IDLE;
         wcnt_q <= wcnt_d;
         beat_q <= beat_d;
         iack_q <= iack_d;
         line_q <= line_d;
         read_q <= read_d;
         data_q <= data_d;
         ie_q <= ie_d && rstn_q;
         ack_n_q <= ack_n_d || !rstn_q;
         err_n_q <= err_n_d || !rstn_q;
         rcnt_q <= rcnt_d;
         rstn_q <= rstn_d;
         cyc_seen_o <= seen_d && rstn_q;
         iack_seen_o <= iseen_d && rstn_q;
         timeout_o <= to_d && rstn_q;
      end
   end

   assign bus.read_data_bus = data_q;
   assign bus.input_enable = ie_q;
   assign bus.transfer_ack_n = ack_n_q;
   assign bus.transfer_error_ack_n = err_n_q;
   assign bus.bus_reset_n = rstn_q;
endmodule

// ### verilog/bct_core_end.sv
// Processor end: master bus cycles, acknowledge reads and access error handling
`timescale 1ns/1ps
`include "bct_regs.svh"
module bct_core_end (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Bus
   bct_bus_if.core bus,
   // Strap
   input wire logic alt_ack_mode_strap_i,
   // Transfer request
   input wire logic req_i,
   input wire bct_pkg::bct_kind_t req_kind_i,
   input wire logic [31:0] req_addr_i,
   input wire logic [1:0] req_size_i,
   input wire logic [2:0] req_level_i,
   input wire logic [1:0] req_beat_i,
   input wire logic req_misaligned_i,
   // Execution context
   input wire logic use_instr_i,
   input wire logic flush_i,
   input wire logic stacking_i,
   input wire logic stopped_i,
   input wire logic addr_err_i,
   input wire logic wp_err_i,
   input wire logic dbg_cpu_access_i,
   // Results
   output logic busy_o,
   output logic done_o,
   output logic [31:0] rdata_o,
   output logic [7:0] vector_o,
   output logic acc_err_o,
   output logic err_unattr_o,
   output logic prefetch_pend_o,
   output logic line_inval_o,
   output logic line_fill_o,
   output logic line_drop_o,
   output logic [3:0] processor_status_o
);
   bct_pkg::bct_core_state_t state_q, state_d;
   bct_pkg::bct_kind_t kind_q, kind_d;
   logic [1:0] beat_q, beat_d, rbeat_q, rbeat_d;
   logic misal_q, misal_d, alt_q;
   logic [31:0] addr_q, addr_d;
   logic [2:0] tm_q, tm_d;
   logic [1:0] tt_q, tt_d, size_q, size_d;
   logic rw_q, rw_d, ts_n_q, ts_n_d;
   logic busy_d, done_d, err_d, unattr_d, pend_d, inval_d, fill_d, drop_d;
   logic [31:0] rdata_d;
   logic [7:0] vec_d;
   logic [3:0] pst_d;
   logic rst, bus_err, bus_ack, raise, pf_err, halt_now, is_line;

   // Acknowledge address for either encoding
   function automatic logic [31:0] iack_addr(input logic alt, input logic [2:0] lvl);
      iack_addr = alt ? {`BCT_ALT_ADDR_HI, lvl, `BCT_ALT_ADDR_LO} : {`BCT_NAT_ADDR_HI, lvl, `BCT_NAT_ADDR_LO};
   endfunction

   // A line longword error is taken now only when execution wanted it
   function automatic logic line_err_now(input logic [1:0] beat, input logic [1:0] want, input logic mis);
      line_err_now = (beat == want) || (mis && (want != `BCT_LAST_BEAT) && (beat == want + 2'h1));
   endfunction

   function automatic logic kind_is_line(input bct_pkg::bct_kind_t k);
      kind_is_line = (k == bct_pkg::BCT_KIND_LINE_INSTR) || (k == bct_pkg::BCT_KIND_LINE_DATA);
   endfunction

   // Bus reset comes from logic on this clock, so it needs no synchroniser
   assign rst = reset_i || !bus.bus_reset_n;

   always_comb begin
      state_d = state_q;
      kind_d = kind_q;
      beat_d = beat_q;
      rbeat_d = rbeat_q;
      misal_d = misal_q;
      addr_d = addr_q;
      tm_d = tm_q;
      tt_d = tt_q;
      size_d = size_q;
      rw_d = rw_q;
      ts_n_d = 1'b1;
      busy_d = busy_o;
      rdata_d = rdata_o;
      vec_d = vector_o;
      pst_d = processor_status_o;
      done_d = 1'b0;
      err_d = 1'b0;
      unattr_d = 1'b0;
      inval_d = 1'b0;
      fill_d = 1'b0;
      drop_d = 1'b0;
      raise = 1'b0;
      pf_err = 1'b0;
      is_line = kind_is_line(kind_q);
      bus_err = (state_q == bct_pkg::BCT_ST_WAIT) && !bus.transfer_error_ack_n;
      bus_ack = (state_q == bct_pkg::BCT_ST_WAIT) && !bus.transfer_ack_n;
      case (state_q)
         bct_pkg::BCT_ST_IDLE: begin
            if (req_i) begin
               kind_d = req_kind_i;
               beat_d = 2'h0;
               rbeat_d = req_beat_i;
               misal_d = req_misaligned_i;
               ts_n_d = 1'b0;
               busy_d = 1'b1;
               state_d = bct_pkg::BCT_ST_START;
               if (req_kind_i == bct_pkg::BCT_KIND_IACK) begin
                  addr_d = iack_addr(alt_q, req_level_i);
                  tm_d = alt_q ? `BCT_TM_ALT_IACK : req_level_i;
                  tt_d = alt_q ? `BCT_TT_ALT_IACK : `BCT_TT_NAT_IACK;
                  rw_d = 1'b1;
                  size_d = `BCT_SIZE_BYTE;
               end else begin
                  addr_d = req_addr_i;
                  tm_d = `BCT_TM_NORMAL;
                  tt_d = `BCT_TT_NORMAL;
                  rw_d = !((req_kind_i == bct_pkg::BCT_KIND_WRITE) || (req_kind_i == bct_pkg::BCT_KIND_BUF_WRITE));
                  size_d = kind_is_line(req_kind_i) ? `BCT_SIZE_LINE : req_size_i;
               end
               // Old line goes invalid in the same cycle as the fill's transfer start reaches the bus
               inval_d = (req_kind_i == bct_pkg::BCT_KIND_LINE_INSTR);
            end
         end
         bct_pkg::BCT_ST_START: begin
            ts_n_d = 1'b1;
            state_d = bct_pkg::BCT_ST_WAIT;
         end
         bct_pkg::BCT_ST_WAIT: begin
            if (bus_err) begin
               // Error beats acknowledge; remaining line beats are dropped
               state_d = bct_pkg::BCT_ST_IDLE;
               busy_d = 1'b0;
               done_d = 1'b1;
               if (kind_q == bct_pkg::BCT_KIND_IACK) begin
                  vec_d = bus.read_data_bus[`BCT_VEC_MSB:`BCT_VEC_LSB];
               end
               case (kind_q)
                  bct_pkg::BCT_KIND_PREFETCH: pf_err = 1'b1;
                  bct_pkg::BCT_KIND_LINE_INSTR,
                  bct_pkg::BCT_KIND_LINE_DATA: begin
                     if (line_err_now(beat_q, rbeat_q, misal_q)) begin
                        raise = 1'b1;
                     end else begin
                        drop_d = 1'b1;
                     end
                  end
                  bct_pkg::BCT_KIND_BUF_WRITE: begin
                     raise = 1'b1;
                     unattr_d = 1'b1;
                  end
                  default: raise = 1'b1;
               endcase
            end else if (bus_ack) begin
               if (kind_q == bct_pkg::BCT_KIND_IACK) begin
                  vec_d = bus.read_data_bus[`BCT_VEC_MSB:`BCT_VEC_LSB];
               end else if (rw_q) begin
                  rdata_d = bus.read_data_bus;
               end
               if (is_line && (beat_q != `BCT_LAST_BEAT)) begin
                  beat_d = beat_q + 2'h1;
               end else begin
                  state_d = bct_pkg::BCT_ST_IDLE;
                  busy_d = 1'b0;
                  done_d = 1'b1;
                  fill_d = is_line;
               end
            end
            // Neither strobe: stay and resample next edge
         end
         bct_pkg::BCT_ST_HALT: begin
            pst_d = `BCT_PST_HALT;
         end
         default: state_d = bct_pkg::BCT_ST_IDLE;
      endcase
      // Write protection and debug processor space access are the other sources
      if (wp_err_i || (dbg_cpu_access_i && !stopped_i && (state_q != bct_pkg::BCT_ST_HALT))) begin
         raise = 1'b1;
      end
      // Pending prefetch error: set wins over a same cycle discard
      pend_d = prefetch_pend_o;
      if (use_instr_i && prefetch_pend_o) begin
         raise = 1'b1;
         pend_d = 1'b0;
      end
      if (flush_i) begin
         pend_d = 1'b0;
      end
      if (pf_err) begin
         pend_d = 1'b1;
      end
      halt_now = stacking_i && (raise || addr_err_i) && (state_q != bct_pkg::BCT_ST_HALT);
      if (halt_now) begin
         state_d = bct_pkg::BCT_ST_HALT;
         pst_d = `BCT_PST_HALT;
         busy_d = 1'b0;
         ts_n_d = 1'b1;
      end
      err_d = raise && !halt_now && (state_q != bct_pkg::BCT_ST_HALT);
   end

   always_ff @(posedge clk_i) begin
      if (rst) begin
         // Strap is static; caught every reset cycle and held afterwards
         alt_q <= alt_ack_mode_strap_i;
         state_q <= bct_pkg::BCT_ST_IDLE;
         kind_q <= bct_pkg::BCT_KIND_OPERAND;
         beat_q <= 2'h0;
         rbeat_q <= 2'h0;
         misal_q <= 1'b0;
         addr_q <= 32'h00000000;
         tm_q <= `BCT_TM_NORMAL;
         tt_q <= `BCT_TT_NORMAL;
         size_q <= `BCT_SIZE_LONG;
         rw_q <= 1'b1;
         ts_n_q <= 1'b1;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         rdata_o <= 32'h00000000;
         vector_o <= 8'h00;
         acc_err_o <= 1'b0;
         err_unattr_o <= 1'b0;
         prefetch_pend_o <= 1'b0;
         line_inval_o <= 1'b0;
         line_fill_o <= 1'b0;
         line_drop_o <= 1'b0;
         processor_status_o <= `BCT_PST_RUN;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         beat_q <= beat_d;
         rbeat_q <= rbeat_d;
         misal_q <= misal_d;
         addr_q <= addr_d;
         tm_q <= tm_d;
         tt_q <= tt_d;
         size_q <= size_d;
         rw_q <= rw_d;
         ts_n_q <= ts_n_d;
         busy_o <= busy_d;
         done_o <= done_d;
         rdata_o <= rdata_d;
         vector_o <= vec_d;
         acc_err_o <= err_d;
         err_unattr_o <= unattr_d;
         prefetch_pend_o <= pend_d;
         line_inval_o <= inval_d;
         line_fill_o <= fill_d;
         line_drop_o <= drop_d;
         processor_status_o <= pst_d;
      end
   end

   assign bus.master_address = addr_q;
   assign bus.transfer_modifier = tm_q;
   assign bus.transfer_type = tt_q;
   assign bus.read_write_n = rw_q;
   assign bus.transfer_size = size_q;
   assign bus.transfer_start_n = ts_n_q;
endmodule

// ### dv/bct_link_chk.sv
// Concurrent checks on the bus between the processor end and the peripheral end
`timescale 1ns/1ps
module bct_link_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Core side
   input wire logic [31:0] master_address,
   input wire logic [2:0] transfer_modifier,
   input wire logic [1:0] transfer_type,
   input wire logic read_write_n,
   input wire logic [1:0] transfer_size,
   input wire logic transfer_start_n,
   // Peer side
   input wire logic [31:0] read_data_bus,
   input wire logic input_enable,
   input wire logic transfer_ack_n,
   input wire logic transfer_error_ack_n,
   input wire logic bus_reset_n
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   // Saturates so a long bus reset cannot wrap back below the minimum
   logic [2:0] low_cnt_q;
   logic [2:0] low_cnt_d;

   always_comb begin
      low_cnt_d = 3'h0;
      if (!bus_reset_n && !reset_i) begin
         low_cnt_d = (low_cnt_q == 3'h7) ? 3'h7 : low_cnt_q + 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      low_cnt_q <= low_cnt_d;
   end

   a_iack_alt_pattern: assert property (
      !transfer_start_n && transfer_modifier == 3'h7 && transfer_type == 2'h0 |-> master_address[31:4] == 28'hFFFFFFF
      && master_address[0] && read_write_n && transfer_size == 2'h1) else $error("acknowledge pattern wrong");
   a_start_one_cycle: assert property (
      $fell(transfer_start_n) |=> transfer_start_n) else $error("start held too long");
   a_answer_bounded: assert property (
      $fell(transfer_start_n) |-> ##[1:300] (!transfer_ack_n || !transfer_error_ack_n)) else $error("cycle never ended");
   a_ack_release: assert property (
      !transfer_ack_n && transfer_size != 2'h3 |=> transfer_ack_n && !input_enable) else $error("ack not released");
   a_err_release: assert property (
      !transfer_error_ack_n |=> transfer_error_ack_n && !input_enable) else $error("error ack not released");
   a_enable_with_term: assert property (
      input_enable |-> !transfer_ack_n || !transfer_error_ack_n) else $error("enable without termination");
   a_spurious_vector: assert property (
      !transfer_error_ack_n && (transfer_modifier == 3'h7 || transfer_type == 2'h3)
      |-> input_enable && read_data_bus[31:24] == 8'h18) else $error("spurious vector wrong");
   a_reset_min_hold: assert property (
      $rose(bus_reset_n) |-> low_cnt_q >= 3'h6) else $error("bus reset too short");
   a_quiet_in_reset: assert property (
      !bus_reset_n && !$past(bus_reset_n) |-> transfer_start_n) else $error("start during bus reset");
endmodule

// ### dv/tb.sv
// Testbench joining both ends of the termination link
`timescale 1ns/1ps
module tb;
   logic clk_i, reset_i, strap, req, mis, use_instr, flush, stacking, stopped, addr_err, wp_err, dbg;
   logic rst_req, iack_present, spur_ack, dev_present, err_inj, done, acc, unattr, pend, inval, fill, drop;
   bct_pkg::bct_kind_t kind;
   logic [31:0] addr, rd_data, rdata;
   logic [1:0] size, beat;
   logic [2:0] level;
   logic [7:0] vec, vector;
   logic [3:0] waits, pstat;
   int cnt[6];
   int n_fail, n_compared;

   bct_bus_if bus_if();

   bct_core_end bct_core_end_inst (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if), .alt_ack_mode_strap_i(strap),
      .req_i(req), .req_kind_i(kind), .req_addr_i(addr), .req_size_i(size), .req_level_i(level), .req_beat_i(beat),
      .req_misaligned_i(mis), .use_instr_i(use_instr), .flush_i(flush), .stacking_i(stacking), .stopped_i(stopped),
      .addr_err_i(addr_err), .wp_err_i(wp_err), .dbg_cpu_access_i(dbg), .busy_o(), .done_o(done), .rdata_o(rdata),
      .vector_o(vector), .acc_err_o(acc), .err_unattr_o(unattr), .prefetch_pend_o(pend), .line_inval_o(inval),
      .line_fill_o(fill), .line_drop_o(drop), .processor_status_o(pstat));

   bct_peer_end bct_peer_end_inst (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if), .rst_req_i(rst_req),
      .iack_present_i(iack_present), .iack_vector_i(vec), .spur_use_ack_i(spur_ack), .dev_present_i(dev_present),
      .err_inject_i(err_inj), .wait_cycles_i(waits), .rd_data_i(rd_data), .cyc_seen_o(), .iack_seen_o(),
      .timeout_o());

   bct_link_chk bct_link_chk_inst (.clk_i(clk_i), .reset_i(reset_i), .master_address(bus_if.master_address),
      .transfer_modifier(bus_if.transfer_modifier), .transfer_type(bus_if.transfer_type),
      .read_write_n(bus_if.read_write_n), .transfer_size(bus_if.transfer_size),
      .transfer_start_n(bus_if.transfer_start_n), .read_data_bus(bus_if.read_data_bus),
      .input_enable(bus_if.input_enable), .transfer_ack_n(bus_if.transfer_ack_n),
      .transfer_error_ack_n(bus_if.transfer_error_ack_n), .bus_reset_n(bus_if.bus_reset_n));

   always #4 clk_i = ~clk_i;

   // Pulses are counted so their exact cycle does not matter to the checks
   always @(posedge clk_i) begin
      cnt[0] += (acc === 1'b1);
      cnt[1] += (unattr === 1'b1);
      cnt[2] += (drop === 1'b1);
      cnt[3] += (fill === 1'b1);
      cnt[4] += (inval === 1'b1);
      cnt[5] += (bus_if.transfer_ack_n === 1'b0 || bus_if.transfer_error_ack_n === 1'b0);
   end

   task end_of_test;
      begin
         $display("compared %0d failed %0d", n_compared, n_fail);
         if (n_fail == 0 && n_compared > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask

   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      begin
         n_compared++;
         if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask

   task wait_rst;
      int i;
      int n;
      begin
         n = 0;
         for (i = 0; i < 60 && !(n > 0 && bus_if.bus_reset_n === 1'b1); i++) begin
            @(negedge clk_i);
            if (bus_if.bus_reset_n === 1'b0) n++;
         end
         if (i == 60) n_fail++;
         if (i == 60) end_of_test();
         chk("bus reset length", n >= 6, 1);
      end
   endtask

   // Counts per op: term, inval, fill, drop, unattr, acc as nibbles of e
   task op(input bct_pkg::bct_kind_t k, input logic [1:0] bt, input logic [5:0] m, input logic [23:0] e);
      int b[6];
      int i;
      begin
         @(negedge clk_i);
         b = cnt;
         @(posedge clk_i);
         kind <= k;
         beat <= bt;
         req <= 1'b1;
         @(posedge clk_i);
         req <= 1'b0;
         for (i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk_i);
         if (i == 400) n_fail++;
         if (i == 400) end_of_test();
         repeat (3) @(negedge clk_i);
         for (i = 0; i < 6; i++) if (m[i]) chk("pulse count", cnt[i] - b[i], e[4*i +: 4]);
      end
   endtask

   // Context error source: 0 protect, 1 debug, 2 address, 3 use of prefetch
   task ctx(input int s, input int e);
      int a;
      begin
         @(negedge clk_i);
         a = cnt[0];
         @(posedge clk_i);
         {use_instr, addr_err, dbg, wp_err} <= 4'h1 << s;
         @(posedge clk_i);
         {use_instr, addr_err, dbg, wp_err} <= 4'h0;
         repeat (3) @(negedge clk_i);
         chk("access errors", cnt[0] - a, e);
      end
   endtask

   initial begin
      {clk_i, strap, req, mis, use_instr, flush, stacking, stopped, addr_err, wp_err, dbg} = 11'h200;
      {reset_i, rst_req, iack_present, spur_ack, dev_present, err_inj} = 6'h26;
      kind = bct_pkg::BCT_KIND_IACK;
      addr = 32'h00001000;
      rd_data = 32'hCAFE0123;
      {size, beat, level, vec, waits} = 19'h055A0;
      {n_fail, n_compared} = 0;
      cnt = '{default: 0};
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      wait_rst();
      op(bct_pkg::BCT_KIND_IACK, 2'h0, 6'h3F, 24'h100000);
      chk("vector", vector, 8'h18);
      @(posedge clk_i);
      {iack_present, spur_ack} <= 2'h2;
      op(bct_pkg::BCT_KIND_IACK, 2'h0, 6'h3F, 24'h100000);
      chk("vector", vector, 8'h5A);
      @(posedge clk_i);
      iack_present <= 1'b0;
      op(bct_pkg::BCT_KIND_IACK, 2'h0, 6'h3F, 24'h100001);
      chk("vector", vector, 8'h18);
      @(posedge clk_i);
      {iack_present, vec, waits} <= 13'h1A73;
      op(bct_pkg::BCT_KIND_IACK, 2'h0, 6'h3F, 24'h100000);
      chk("vector", vector, 8'hA7);
      @(posedge clk_i);
      waits <= 4'h0;
      op(bct_pkg::BCT_KIND_OPERAND, 2'h0, 6'h3F, 24'h100000);
      chk("read data", rdata, 32'hCAFE0123);
      @(posedge clk_i);
      err_inj <= 1'b1;
      op(bct_pkg::BCT_KIND_OPERAND, 2'h0, 6'h3F, 24'h100001);
      op(bct_pkg::BCT_KIND_WRITE, 2'h0, 6'h3F, 24'h100001);
      op(bct_pkg::BCT_KIND_BUF_WRITE, 2'h0, 6'h3F, 24'h100011);
      op(bct_pkg::BCT_KIND_LINE_DATA, 2'h2, 6'h3F, 24'h100100);
      op(bct_pkg::BCT_KIND_LINE_DATA, 2'h0, 6'h3F, 24'h100001);
      op(bct_pkg::BCT_KIND_LINE_INSTR, 2'h1, 6'h3F, 24'h110100);
      op(bct_pkg::BCT_KIND_PREFETCH, 2'h0, 6'h3F, 24'h100000);
      chk("prefetch pending", pend, 1'b1);
      @(posedge clk_i);
      flush <= 1'b1;
      @(posedge clk_i);
      flush <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk("prefetch pending", pend, 1'b0);
      op(bct_pkg::BCT_KIND_PREFETCH, 2'h0, 6'h3F, 24'h100000);
      ctx(3, 1);
      @(posedge clk_i);
      err_inj <= 1'b0;
      op(bct_pkg::BCT_KIND_LINE_INSTR, 2'h0, 6'h3F, 24'h411000);
      ctx(0, 1);
      ctx(1, 1);
      @(posedge clk_i);
      stopped <= 1'b1;
      ctx(1, 0);
      @(posedge clk_i);
      stacking <= 1'b1;
      ctx(2, 0);
      repeat (20) @(negedge clk_i);
      chk("status", pstat, 4'hF);
      @(posedge clk_i);
      {strap, stacking, rst_req, level, vec} <= 14'h0F3C;
      @(posedge clk_i);
      rst_req <= 1'b0;
      wait_rst();
      chk("status", pstat, 4'h0);
      op(bct_pkg::BCT_KIND_IACK, 2'h0, 6'h3F, 24'h100000);
      chk("vector", vector, 8'h3C);
      end_of_test();
   end
endmodule
